/* File: table_interpolate_frame_sync.sv */
`timescale 1ns/1ps
`include "tif_cfg.svh"

module table_interpolate_frame_sync (
  input  wire logic         CLK_IN,
  input  wire logic         RSTN_IN,
  input  wire logic         CMD_VALID_IN,
  input  tif_pkg::cmd_t     CMD_IN,
  output logic              CMD_READY_OUT,
  input  wire logic         BUS_IDLE_IN,
  output tif_pkg::mem_t     MEM_OUT,
  input  wire logic         MEM_ACK_IN,
  input  wire logic [31:0]  MEM_RDATA_IN,
  output logic              RES_VALID_OUT,
  output tif_pkg::res_t     RES_OUT
);
  import tif_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [33:0] extend(input logic [31:0] v, input logic [1:0] sz,
                                         input logic sgn);
    logic [33:0] r;
    r = '0;
    case (sz)
      `SZ_BYTE: r = {{26{sgn & v[7]}}, v[7:0]};
      `SZ_WORD: r = {{18{sgn & v[15]}}, v[15:0]};
      default:  r = {{2{sgn & v[31]}}, v};
    endcase
    return r;
  endfunction

  function automatic logic [31:0] entry_addr(input logic [31:0] base, input logic [8:0] n,
                                             input logic [1:0] sz);
    logic [31:0] off;
    off = {23'h0, n};
    case (sz)
      `SZ_BYTE: entry_addr = base + off;
      `SZ_WORD: entry_addr = base + {off[30:0], 1'b0};
      default:  entry_addr = base + {off[29:0], 2'b00};
    endcase
  endfunction

  st_t q;
  st_t d;

  // ****************************************
  // Interpolation datapath
  // ****************************************
  logic               is_signed;
  logic               is_rounded;
  logic [7:0]         entry_n;
  logic [7:0]         frac;
  logic [33:0]        y0e;
  logic [33:0]        y1e;
  logic signed [34:0] diff;
  logic signed [43:0] prod;
  logic signed [43:0] acc;
  logic [7:0]         frac_bits;
  logic               round_up;
  logic [31:0]        rounded;
  logic [31:0]        unrounded;

  assign is_signed  = (q.cmd.mode == INTERP_SIGNED_ROUNDED) ||
                      (q.cmd.mode == INTERP_SIGNED_UNROUNDED);          // [RULE10]
  assign is_rounded = (q.cmd.mode == INTERP_SIGNED_ROUNDED) ||
                      (q.cmd.mode == INTERP_UNSIGNED_ROUNDED);
  assign entry_n    = q.cmd.independent_var_reg[`ENTRY_MSB:`ENTRY_LSB]; // [RULE1]
  // Pair form takes its fraction from the destination register
  assign frac       = (q.cmd.op == OP_TBL_PAIR) ?
                      q.cmd.surface_fraction_reg[`FRAC_MSB:`FRAC_LSB] :
                      q.cmd.independent_var_reg[`FRAC_MSB:`FRAC_LSB];  // [RULE1] [RULE5]
  assign y0e        = extend(q.y0, q.cmd.size, is_signed);              // [RULE12]
  assign y1e        = extend(q.y1, q.cmd.size, is_signed);              // [RULE12]
  assign diff       = $signed({y1e[33], y1e}) - $signed({y0e[33], y0e});
  // Fraction is unsigned, so widen with a zero before the signed product
  assign prod       = 44'(diff * $signed({1'b0, frac}));                 // [RULE2]
  assign acc        = ($signed({{10{y0e[33]}}, y0e}) <<< `FRAC_BITS) + prod; // [RULE2]
  assign frac_bits  = acc[7:0];
  assign round_up   = (frac_bits > `HALF_LSB) ||
                      ((frac_bits == `HALF_LSB) && acc[8]);             // [RULE3]
  assign rounded    = acc[39:8] + {31'h0, round_up};                    // [RULE3] [RULE10]
  // Unrounded keeps eight bits below the radix point for exact sums
  assign unrounded  = acc[31:0];                                        // [RULE4] [RULE10]

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    d = q;
    d.res_valid = 1'b0;
    d.res = '0;
    case (q.state)
      ST_IDLE:
      begin
        if (CMD_VALID_IN)
        begin
          d.cmd = CMD_IN;
          case (CMD_IN.op)
            OP_TBL_MEM:
            begin
              d.mem.req  = 1'b1;                                        // [RULE11]
              d.mem.we   = 1'b0;
              d.mem.size = CMD_IN.size;
              d.mem.addr = entry_addr(CMD_IN.ea,
                {1'b0, CMD_IN.independent_var_reg[`ENTRY_MSB:`ENTRY_LSB]},
                CMD_IN.size);                                           // [RULE1]
              d.state    = ST_RD0;
            end
            OP_TBL_PAIR:
            begin
              d.y0    = CMD_IN.pair_lo;                                 // [RULE5] [RULE11]
              d.y1    = CMD_IN.pair_hi;
              d.state = ST_CALC;
            end
            OP_LINK:
            begin
              d.mem.req   = 1'b1;                                       // [RULE7]
              d.mem.we    = 1'b1;
              d.mem.size  = `SZ_LONG;
              d.mem.addr  = CMD_IN.sp - `PUSH_BYTES;
              d.mem.wdata = CMD_IN.areg;
              d.state     = ST_PUSH;
            end
            OP_FRAME_RM:
            begin
              d.mem.req  = 1'b1;                                        // [RULE8]
              d.mem.we   = 1'b0;
              d.mem.size = `SZ_LONG;
              d.mem.addr = CMD_IN.areg;
              d.state    = ST_POP;
            end
            default:
              d.state = ST_SYNC;                                        // [RULE9]
          endcase
        end
      end
      ST_RD0:
      begin
        if (MEM_ACK_IN)
        begin
          d.y0       = MEM_RDATA_IN;
          d.mem.addr = entry_addr(q.cmd.ea, {1'b0, entry_n} + 9'h1, q.cmd.size); // [RULE2]
          d.state    = ST_RD1;
        end
      end
      ST_RD1:
      begin
        if (MEM_ACK_IN)
        begin
          d.y1      = MEM_RDATA_IN;
          d.mem.req = 1'b0;
          d.state   = ST_CALC;
        end
      end
      ST_CALC:
      begin
        d.res.dst_we   = 1'b1;
        d.res.dst_size = q.cmd.size;
        d.res.dst_data = is_rounded ? rounded : unrounded;              // [RULE3] [RULE4]
        d.res_valid    = 1'b1;
        d.state        = ST_IDLE;
      end
      ST_PUSH:
      begin
        if (MEM_ACK_IN)
        begin
          d.mem.req     = 1'b0;
          d.res.an_we   = 1'b1;                                         // [RULE7]
          d.res.an_data = q.mem.addr;
          d.res.sp_we   = 1'b1;
          d.res.sp_data = q.mem.addr + q.cmd.disp;                      // [RULE7]
          d.res_valid   = 1'b1;
          d.state       = ST_IDLE;
        end
      end
      ST_POP:
      begin
        if (MEM_ACK_IN)
        begin
          d.mem.req     = 1'b0;
          d.res.sp_we   = 1'b1;                                         // [RULE8]
          d.res.sp_data = q.cmd.areg + `PUSH_BYTES;
          d.res.an_we   = 1'b1;
          d.res.an_data = MEM_RDATA_IN;                                 // [RULE8]
          d.res_valid   = 1'b1;
          d.state       = ST_IDLE;
        end
      end
      ST_SYNC:
      begin
        // Own bus is already idle here; wait for every other pending cycle
        if (BUS_IDLE_IN)
        begin
          d.res_valid = 1'b1;                                           // [RULE9]
          d.state     = ST_IDLE;
        end
      end
      default:
      begin
        d = '0;
        d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      q <= '0;
      q.state <= ST_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // One command at a time keeps earlier work finished before the next starts
  assign CMD_READY_OUT = (q.state == ST_IDLE);                          // [RULE9]
  assign MEM_OUT       = q.mem;
  assign RES_VALID_OUT = q.res_valid;
  assign RES_OUT       = q.res;

endmodule

/* File: tb_table_interpolate_frame_sync.sv */
`timescale 1ns/1ps
module tb_table_interpolate_frame_sync;
  import tif_pkg::*;
  logic        CLK_IN = 0;
  logic        RSTN_IN = 0;
  logic        CMD_VALID_IN = 0;
  cmd_t        CMD_IN = '0;
  logic        BUS_IDLE_IN = 1;
  logic        CMD_READY_OUT, MEM_ACK_IN, RES_VALID_OUT;
  mem_t        MEM_OUT;
  res_t        RES_OUT, r;
  logic [31:0] MEM_RDATA_IN, wr_addr, wr_data;
  logic [3:0]  wait_cnt = 4'h0;
  int          err_count = 0, num_checks = 0, cyc = 0, t;
  always #12.5 CLK_IN = ~CLK_IN;
  table_interpolate_frame_sync table_interpolate_frame_sync_i (.CLK_IN(CLK_IN),
    .RSTN_IN(RSTN_IN), .CMD_VALID_IN(CMD_VALID_IN), .CMD_IN(CMD_IN),
    .CMD_READY_OUT(CMD_READY_OUT), .BUS_IDLE_IN(BUS_IDLE_IN), .MEM_OUT(MEM_OUT),
    .MEM_ACK_IN(MEM_ACK_IN), .MEM_RDATA_IN(MEM_RDATA_IN), .RES_VALID_OUT(RES_VALID_OUT),
    .RES_OUT(RES_OUT));
  tif_mem_model tif_mem_model_i (.clk_in(CLK_IN), .rstn_in(RSTN_IN), .mem_in(MEM_OUT),
    .wait_in(wait_cnt), .ack_out(MEM_ACK_IN), .rdata_out(MEM_RDATA_IN),
    .wr_addr_out(wr_addr), .wr_data_out(wr_data));
  // ****
  // Helpers
  // ****
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic run(cmd_t c);
    CMD_IN = c;
    CMD_VALID_IN = 1;
    while (CMD_READY_OUT !== 1'b1) @(posedge CLK_IN) #2;
    @(posedge CLK_IN) #2;
    CMD_VALID_IN = 0;
    for (int i = 0; i < 40 && RES_VALID_OUT !== 1'b1; i++) @(posedge CLK_IN) #2;
    chk("res_valid", 32'h1, {31'h0, RES_VALID_OUT});
    r = RES_OUT;
  endtask
  function automatic logic [31:0] mval(logic [31:0] a, logic [1:0] sz);
    logic [31:0] v;
    v = a * 32'h9e3779b9;
    return sz == 2'h0 ? {24'h0, v[7:0]} : sz == 2'h1 ? {16'h0, v[15:0]} : v;
  endfunction
  function automatic longint ext(logic [31:0] a, logic [1:0] sz, logic s);
    logic [31:0] m;
    m = sz == 2'h0 ? 32'hff : sz == 2'h1 ? 32'hffff : 32'hffffffff;
    ext = a & m;
    if (s && |(a & (m ^ (m >> 1))))
      ext = ext - longint'(m) - 1;
  endfunction
  // Signed modes are 0 and 1, unrounded modes have bit 0 set
  function automatic logic [31:0] interp(logic [31:0] a, logic [31:0] b, logic [7:0] f,
                                         mode_t m, logic [1:0] sz);
    longint v, q;
    v = ext(a, sz, m < 2) * 256 + longint'(f) * (ext(b, sz, m < 2) - ext(a, sz, m < 2));
    q = v >>> 8;
    if (m[0])
      return v[31:0];
    if (v[7:0] > 8'h80 || (v[7:0] == 8'h80 && q[0]))
      q++;
    return q[31:0];
  endfunction
  // ****
  // Scenarios
  // ****
  task automatic t_pair;
    cmd_t c;
    logic [31:0] e;
    c = '0;
    c.op = OP_TBL_PAIR;
    c.pair_lo = 32'hfffffffd;
    c.pair_hi = 32'h2;
    c.surface_fraction_reg = 32'h80;
    for (int k = 0; k < 12; k++)
    begin
      c.mode = mode_t'(k % 4);
      c.size = 2'(k / 4);
      run(c);
      e = interp(c.pair_lo, 32'h2, 8'h80, c.mode, c.size);
      chk("pair", e, r.dst_data);
      chk("pair_dst", {29'h0, 1'b1, c.size}, {29'h0, r.dst_we, r.dst_size});
    end
    c.surface_fraction_reg = 32'h0;
    c.mode = INTERP_SIGNED_ROUNDED;
    run(c);
    chk("pair_zero", c.pair_lo, r.dst_data);
  endtask
  task automatic t_mem;
    cmd_t c;
    logic [31:0] a, b, x;
    c = '0;
    c.op = OP_TBL_MEM;
    c.independent_var_reg = 32'hffffff40;
    for (int m = 0; m < 5; m++)
    begin
      wait_cnt = 4'(m * 2);
      c.mode = m == 4 ? INTERP_SIGNED_UNROUNDED : mode_t'(m % 4);
      c.size = m == 4 ? 2'h1 : 2'(m % 3);
      c.ea = 32'h1000 * m;
      run(c);
      a = mval(c.ea + (32'hff << c.size), c.size);
      b = mval(c.ea + (32'h100 << c.size), c.size);
      chk("table", interp(a, b, 8'h40, c.mode, c.size), r.dst_data);
      if (m == 1)
        x = r.dst_data;
    end
    c.op = OP_TBL_PAIR;
    c.mode = INTERP_SIGNED_ROUNDED;
    c.size = 2'h2;
    c.pair_lo = x;
    c.pair_hi = r.dst_data;
    c.surface_fraction_reg = 32'hc0;
    run(c);
    chk("surface", interp(x, c.pair_hi, 8'hc0, c.mode, 2'h2), r.dst_data);
  endtask
  task automatic t_frame;
    cmd_t c;
    c = '0;
    c.op = OP_LINK;
    c.areg = 32'hcafe0010;
    c.sp = 32'h8000;
    c.disp = 32'hfffffff0;
    run(c);
    chk("push_addr", 32'h7ffc, wr_addr);
    chk("push_data", c.areg, wr_data);
    chk("link_an", 32'h7ffc, r.an_data);
    chk("link_sp", 32'h7fec, r.sp_data);
    chk("link_we", 32'h6, {29'h0, r.an_we, r.sp_we, r.dst_we});
    c.op = OP_FRAME_RM;
    c.areg = 32'h7ffc;
    wait_cnt = 4'h3;
    run(c);
    chk("unlink_an", mval(32'h7ffc, 2'h2), r.an_data);
    chk("unlink_sp", 32'h8000, r.sp_data);
    chk("unlink_we", 32'h6, {29'h0, r.an_we, r.sp_we, r.dst_we});
  endtask
  task automatic t_nop;
    t = cyc;
    run('0);
    chk("nop_fast", 32'd2, 32'(cyc - t));
    BUS_IDLE_IN = 0;
    fork
      begin
        repeat (6) @(posedge CLK_IN);
        #2 BUS_IDLE_IN = 1;
      end
    join_none
    t = cyc;
    run('0);
    chk("nop_wait", 32'd7, 32'(cyc - t));
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge CLK_IN)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      final_report();
    end
  end
  initial
  begin
    repeat (8) @(posedge CLK_IN);
    #2 RSTN_IN = 1;
    t_pair();
    t_mem();
    t_frame();
    t_nop();
    final_report();
  end
endmodule

/* File: tif_cfg.svh */
// Overview of operation
// RULE1: The entry number is bits 15:8 of the independent variable and the fraction is bits 7:0.
// RULE2: The result is entry n plus fraction times (entry n+1 minus entry n) divided by 256.
// RULE3: The signed rounded variant rounds to nearest with ties going to the even integer.
// RULE4: The signed unrounded variant returns the value with eight fraction bits kept.
// RULE5: The register-pair form interpolates two data registers using the destination fraction.
// RULE6: Software issues the pair form one size larger than the unrounded lookups fed to it.
// RULE7: Frame create pushes a register, loads it with the stack address, then reserves a frame.
// RULE8: Frame remove loads the stack pointer from the register, then pops the saved link.
// RULE9: The no-operation waits for all bus cycles to end and starts after earlier work ends.
// RULE10: The unsigned variants mirror the signed ones, rounded and unrounded, at every size.
// RULE11: Interpolation works on a memory table via an effective address and on a register pair.
// RULE12: Signed variants read entries as two's complement, unsigned ones as unsigned, per size.
`ifndef TIF_CFG_SVH
`define TIF_CFG_SVH

`define SZ_BYTE     2'h0
`define SZ_WORD     2'h1
`define SZ_LONG     2'h2
`define ENTRY_MSB   15
`define ENTRY_LSB   8
`define FRAC_MSB    7
`define FRAC_LSB    0
`define FRAC_BITS   8
`define HALF_LSB    8'h80
`define PUSH_BYTES  32'h4
`define RES_RESET   32'h0

`endif

/* File: tif_mem_model.sv */
`timescale 1ns/1ps
module tif_mem_model (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  tif_pkg::mem_t     mem_in,
  input  wire logic [3:0]   wait_in,
  output logic              ack_out,
  output logic [31:0]       rdata_out,
  output logic [31:0]       wr_addr_out,
  output logic [31:0]       wr_data_out
);
  import tif_pkg::*;
  logic [3:0]  cnt;
  logic [31:0] val;
  // Pattern memory, right justified at the access size
  always_comb
  begin
    val = mem_in.addr * 32'h9e3779b9;
    if (mem_in.size == 2'h0)
      val = {24'h0, val[7:0]};
    else if (mem_in.size == 2'h1)
      val = {16'h0, val[15:0]};
  end
  // Inverted outside ack so stale data never looks valid
  assign rdata_out = ack_out ? val : ~val;
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      ack_out     <= 1'b0;
      cnt         <= 4'h0;
      wr_addr_out <= 32'h0;
      wr_data_out <= 32'h0;
    end
    else
    begin
      ack_out <= mem_in.req && !ack_out && cnt == wait_in;
      cnt     <= (mem_in.req && !ack_out && cnt != wait_in) ? cnt + 4'h1 : 4'h0;
      if (ack_out && mem_in.we)
      begin
        wr_addr_out <= mem_in.addr;
        wr_data_out <= mem_in.wdata;
      end
    end
endmodule

/* File: tif_pkg.sv */
package tif_pkg;

  typedef enum logic [2:0] {
    OP_NOP      = 3'h0,
    OP_TBL_MEM  = 3'h1,
    OP_TBL_PAIR = 3'h2,
    OP_LINK     = 3'h3,
    OP_FRAME_RM = 3'h4
  } op_t;

  typedef enum logic [1:0] {
    INTERP_SIGNED_ROUNDED     = 2'h0,
    INTERP_SIGNED_UNROUNDED   = 2'h1,
    INTERP_UNSIGNED_ROUNDED   = 2'h2,
    INTERP_UNSIGNED_UNROUNDED = 2'h3
  } mode_t;

  typedef struct packed {
    op_t         op;
    mode_t       mode;
    logic [1:0]  size;
    logic [31:0] ea;
    logic [31:0] independent_var_reg;
    logic [31:0] surface_fraction_reg;
    logic [31:0] pair_lo;
    logic [31:0] pair_hi;
    logic [31:0] areg;
    logic [31:0] sp;
    logic [31:0] disp;
  } cmd_t;

  typedef struct packed {
    logic        dst_we;
    logic [1:0]  dst_size;
    logic [31:0] dst_data;
    logic        an_we;
    logic [31:0] an_data;
    logic        sp_we;
    logic [31:0] sp_data;
  } res_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_RD0  = 7'h02,
    ST_RD1  = 7'h04,
    ST_CALC = 7'h08,
    ST_PUSH = 7'h10,
    ST_POP  = 7'h20,
    ST_SYNC = 7'h40
  } state_t;

  typedef struct packed {
    state_t      state;
    cmd_t        cmd;
    logic [31:0] y0;
    logic [31:0] y1;
    mem_t        mem;
    res_t        res;
    logic        res_valid;
  } st_t;

endpackage

/* File: tif_properties.sv */
`timescale 1ns/1ps
module tif_properties (
  input  wire logic         CLK_IN,
  input  wire logic         RSTN_IN,
  input  wire logic         CMD_VALID_IN,
  input  tif_pkg::cmd_t     CMD_IN,
  input  wire logic         CMD_READY_OUT,
  input  wire logic         BUS_IDLE_IN,
  input  tif_pkg::mem_t     MEM_OUT,
  input  wire logic         MEM_ACK_IN,
  input  wire logic [31:0]  MEM_RDATA_IN,
  input  wire logic         RES_VALID_OUT,
  input  tif_pkg::res_t     RES_OUT
);
  import tif_pkg::*;
  // ****
  // Checks
  // ****
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);
  logic tk;
  assign tk = CMD_VALID_IN && CMD_READY_OUT;
  a_pair_latency: assert property (tk && CMD_IN.op == OP_TBL_PAIR |-> ##2 RES_VALID_OUT)
    else $error("pair result not two cycles after take");
  a_pair_exact: assert property (tk && CMD_IN.op == OP_TBL_PAIR && CMD_IN.size == 2'h2
    && CMD_IN.mode == INTERP_SIGNED_ROUNDED && CMD_IN.surface_fraction_reg[7:0] == 8'h0
    |-> ##2 RES_OUT.dst_data == $past(CMD_IN.pair_lo, 2))
    else $error("zero fraction does not return entry n");
  a_mem_first: assert property (tk && CMD_IN.op == OP_TBL_MEM
    |=> MEM_OUT.req && !MEM_OUT.we && MEM_OUT.addr == $past(CMD_IN.ea)
    + ({24'h0, $past(CMD_IN.independent_var_reg[15:8])} << $past(CMD_IN.size)))
    else $error("first table read address wrong");
  a_link_push: assert property (tk && CMD_IN.op == OP_LINK |=> MEM_OUT.req && MEM_OUT.we
    && MEM_OUT.addr == $past(CMD_IN.sp) - 32'h4 && MEM_OUT.wdata == $past(CMD_IN.areg))
    else $error("frame push wrong");
  a_remove_read: assert property (tk && CMD_IN.op == OP_FRAME_RM |=> MEM_OUT.req
    && !MEM_OUT.we && MEM_OUT.addr == $past(CMD_IN.areg))
    else $error("frame pop address wrong");
  a_nop_hold: assert property (tk && CMD_IN.op == OP_NOP ##1 !BUS_IDLE_IN
    |=> !RES_VALID_OUT)
    else $error("sync finished with bus busy");
  a_nop_done: assert property (tk && CMD_IN.op == OP_NOP ##1 BUS_IDLE_IN
    |=> RES_VALID_OUT)
    else $error("sync late with bus idle");
  a_req_stands: assert property (MEM_OUT.req && !MEM_ACK_IN |=> MEM_OUT.req
    && $stable(MEM_OUT.addr) && $stable(MEM_OUT.we))
    else $error("bus request dropped before ack");
endmodule

bind table_interpolate_frame_sync tif_properties tif_properties_i (
  .CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .CMD_VALID_IN(CMD_VALID_IN), .CMD_IN(CMD_IN),
  .CMD_READY_OUT(CMD_READY_OUT), .BUS_IDLE_IN(BUS_IDLE_IN), .MEM_OUT(MEM_OUT),
  .MEM_ACK_IN(MEM_ACK_IN), .MEM_RDATA_IN(MEM_RDATA_IN), .RES_VALID_OUT(RES_VALID_OUT),
  .RES_OUT(RES_OUT));
